//--- rtl/fsc_pkg.sv
/*
 Constants, modes and register map for the FIR stream control shell and its controller.
 Assumes one clock for both ends and software reaching the controller over AXI4-Lite.
*/
package fsc_pkg;
    typedef enum logic [1:0] {fsc_tlast_none, fsc_tlast_vector, fsc_tlast_packet} fsc_tlast_t;
    typedef enum logic [1:0] {fsc_user_none, fsc_user_field, fsc_channel_tag_mode,
                              fsc_user_and_tag} fsc_user_t;
    typedef enum logic {fsc_sync_vector, fsc_sync_packet} fsc_sync_t;
    typedef enum logic {fsc_single_coef_set, fsc_per_channel_coef_set} fsc_method_t;

    localparam int FSC_AXI_AW = 8;
    localparam logic [7:0] FSC_REG_SAMPLE = 8'h00;
    localparam logic [7:0] FSC_REG_FLAGS = 8'h04;
    localparam logic [7:0] FSC_REG_CONFIG = 8'h08;
    localparam logic [7:0] FSC_REG_RELOAD = 8'h0C;
    localparam logic [7:0] FSC_REG_RELOAD_LAST = 8'h10;
    localparam logic [7:0] FSC_REG_STATUS = 8'h14;
    localparam logic [7:0] FSC_REG_OUT_DATA = 8'h18;
    localparam logic [7:0] FSC_REG_OUT_INFO = 8'h1C;
    localparam logic [7:0] FSC_REG_OUT_COEF = 8'h20;
    localparam logic [7:0] FSC_REG_CTRL = 8'h24;

    localparam int FSC_FLAGS_LAST_BIT = 0;
    localparam int FSC_FLAGS_USER_LSB = 8;
    localparam int FSC_INFO_USER_LSB = 0;
    localparam int FSC_INFO_LAST_BIT = 8;
    localparam int FSC_INFO_SET_LSB = 16;
    localparam int FSC_ST_SAMPLE_BIT = 0;
    localparam int FSC_ST_CONFIG_BIT = 1;
    localparam int FSC_ST_RELOAD_BIT = 2;
    localparam int FSC_ST_OUT_BIT = 3;
    localparam int FSC_CTRL_SINK_BIT = 0;
    localparam logic [31:0] FSC_FLAGS_RESET = 32'h0000_0000;
    localparam logic [31:0] FSC_CTRL_RESET = 32'h0000_0001;

    localparam logic [1:0] FSC_RESP_OKAY = 2'h0;
    localparam logic [1:0] FSC_RESP_SLVERR = 2'h2;

    localparam int FSC_NUM_CH = 4;
    localparam int FSC_NUM_SETS = 2;
    localparam int FSC_NUM_TAPS = 5;
    localparam int FSC_RELOAD_SLOTS = 1;
    localparam int FSC_LATENCY = 4;
endpackage

//--- rtl/fsc_if.sv
/*
 Stream channels between the filter shell and its upstream, downstream and control logic.
 Assumes both ends are built with the same width parameters.
*/
interface fsc_if #(
    parameter int DATA_W = 16,
    parameter int USER_W = 8,
    parameter int CFG_W = 8,
    parameter int COEF_W = 16,
    parameter int SET_W = 1
);
    logic s_tvalid;
    logic s_tready;
    logic [DATA_W-1:0] s_tdata;
    logic s_tlast;
    logic [USER_W-1:0] s_tuser;
    logic m_tvalid;
    logic m_tready;
    logic [DATA_W-1:0] m_tdata;
    logic m_tlast;
    logic [USER_W-1:0] m_tuser;
    logic [SET_W-1:0] m_set;
    logic [COEF_W-1:0] m_coef0;
    logic cfg_tvalid;
    logic cfg_tready;
    logic [CFG_W-1:0] cfg_tdata;
    logic rld_tvalid;
    logic rld_tready;
    logic [COEF_W-1:0] rld_tdata;
    logic rld_tlast;

    modport dev (
        input s_tvalid, s_tdata, s_tlast, s_tuser, m_tready, cfg_tvalid, cfg_tdata,
        input rld_tvalid, rld_tdata, rld_tlast,
        output s_tready, m_tvalid, m_tdata, m_tlast, m_tuser, m_set, m_coef0,
        output cfg_tready, rld_tready
    );
    modport host (
        output s_tvalid, s_tdata, s_tlast, s_tuser, m_tready, cfg_tvalid, cfg_tdata,
        output rld_tvalid, rld_tdata, rld_tlast,
        input s_tready, m_tvalid, m_tdata, m_tlast, m_tuser, m_set, m_coef0,
        input cfg_tready, rld_tready
    );
endinterface

//--- rtl/fsc_filter_ctrl.sv
/*
 Streaming control shell of the FIR filter: framing, user field, config and reload.
 Assumes the far side keeps stream handshakes and holds reset at least one cycle; no arithmetic here.
*/
module fsc_filter_ctrl #(
    parameter int DATA_W = 16,
    parameter int USER_W = 8,
    parameter int CFG_W = 8,
    parameter int COEF_W = 16,
    parameter int SET_W = 1,
    parameter int NUM_CH = fsc_pkg::FSC_NUM_CH,
    parameter int NUM_SETS = fsc_pkg::FSC_NUM_SETS,
    parameter int NUM_TAPS = fsc_pkg::FSC_NUM_TAPS,
    parameter int RELOAD_SLOTS = fsc_pkg::FSC_RELOAD_SLOTS,
    parameter int LATENCY = fsc_pkg::FSC_LATENCY,
    parameter bit HAS_TREADY = 1'b1,
    parameter fsc_pkg::fsc_tlast_t TLAST_MODE = fsc_pkg::fsc_tlast_vector,
    parameter fsc_pkg::fsc_user_t USER_MODE = fsc_pkg::fsc_user_field,
    parameter fsc_pkg::fsc_sync_t SYNC_MODE = fsc_pkg::fsc_sync_vector,
    parameter fsc_pkg::fsc_method_t METHOD = fsc_pkg::fsc_single_coef_set
) (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    fsc_if.dev bus
);
    import fsc_pkg::*;

    localparam int CH_W = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
    localparam int TAP_W = (NUM_TAPS > 1) ? $clog2(NUM_TAPS) : 1;
    localparam int SLOT_W = $clog2(RELOAD_SLOTS + 1);

    typedef struct packed {
        logic rst_q;
        logic [CH_W-1:0] ch;
        logic pkt_seen;
        logic [NUM_CH-1:0][SET_W-1:0] cur_set;
        logic [LATENCY-1:0] pv;
        logic [LATENCY-1:0][DATA_W-1:0] pd;
        logic [LATENCY-1:0] pl;
        logic [LATENCY-1:0][USER_W-1:0] pu;
        logic [LATENCY-1:0][SET_W-1:0] ps;
        logic [LATENCY-1:0][COEF_W-1:0] pc;
        logic [NUM_SETS-1:0][NUM_TAPS-1:0][COEF_W-1:0] coef;
        logic [RELOAD_SLOTS-1:0][NUM_TAPS-1:0][COEF_W-1:0] stage;
        logic [SLOT_W-1:0] stage_cnt;
        logic [TAP_W-1:0] tap;
    } fsc_dev_state_t;

    fsc_dev_state_t st;
    fsc_dev_state_t next_st;

    logic adv;
    logic s_fire;
    logic in_last;
    logic cfg_ok;
    logic cfg_fire;
    logic rld_rdy;
    logic rld_fire;
    logic [SET_W-1:0] set_now;
    logic [SET_W-1:0] commit_set;
    logic [USER_W-1:0] user_now;

    // Fields past the configured set count fall back to set 0 rather than index off the table
    function automatic logic [SET_W-1:0] cfg_field(input logic [CFG_W-1:0] d, input int c);
        logic [SET_W-1:0] f;
        f = '0;
        if (NUM_SETS > 1) begin
            if (METHOD == fsc_per_channel_coef_set) begin
                f = d[c*SET_W +: SET_W];
            end else begin
                f = d[SET_W-1:0];
            end
        end
        if (int'(f) >= NUM_SETS) begin
            f = '0;
        end
        return f;
    endfunction

    // Without the ready port the pipe never stalls and downstream must keep up
    assign adv = !HAS_TREADY || !st.pv[LATENCY-1] || bus.m_tready;
    assign s_fire = bus.s_tvalid && adv && !st.rst_q;
    assign in_last = (TLAST_MODE != fsc_tlast_none) && bus.s_tlast;
    // First sample of a round; with one channel every sample is first
    assign cfg_ok = (st.ch == '0) && ((SYNC_MODE == fsc_sync_vector) || st.pkt_seen);
    assign cfg_fire = s_fire && cfg_ok && bus.cfg_tvalid;
    // Reload pauses while a config commits so the slot shift never races a write
    assign rld_rdy = (int'(st.stage_cnt) < RELOAD_SLOTS) && !cfg_fire && !st.rst_q;
    assign rld_fire = bus.rld_tvalid && rld_rdy;

    assign bus.s_tready = adv && !st.rst_q;
    assign bus.cfg_tready = bus.s_tvalid && adv && cfg_ok && !st.rst_q;
    assign bus.rld_tready = rld_rdy;
    assign bus.m_tvalid = st.pv[LATENCY-1];
    assign bus.m_tdata = st.pd[LATENCY-1];
    assign bus.m_tlast = st.pl[LATENCY-1];
    assign bus.m_tuser = st.pu[LATENCY-1];
    assign bus.m_set = st.ps[LATENCY-1];
    assign bus.m_coef0 = st.pc[LATENCY-1];

    always_comb begin
        set_now = cfg_fire ? cfg_field(bus.cfg_tdata, int'(st.ch)) : st.cur_set[st.ch];
        commit_set = cfg_field(bus.cfg_tdata, 0);
        case (USER_MODE)
            fsc_user_none: begin
                user_now = '0;
            end
            fsc_user_field: begin
                user_now = bus.s_tuser;
            end
            fsc_channel_tag_mode: begin
                user_now = USER_W'(st.ch);
            end
            fsc_user_and_tag: begin
                user_now = bus.s_tuser;
                user_now[CH_W-1:0] = st.ch;
            end
            default: begin
                user_now = '0;
            end
        endcase
    end

    always_comb begin
        next_st = st;
        if (st.rst_q) begin
            next_st = '0;
        end else begin
            if (s_fire) begin
                if (TLAST_MODE == fsc_tlast_vector && in_last) begin
                    next_st.ch = '0;
                end else if (st.ch == CH_W'(NUM_CH - 1)) begin
                    next_st.ch = '0;
                end else begin
                    next_st.ch = CH_W'(st.ch + 1'b1);
                end
            end
            // A last-flagged sample in the consuming cycle re-arms the flag
            next_st.pkt_seen = (st.pkt_seen && !cfg_fire) || (s_fire && in_last);
            if (cfg_fire) begin
                for (int c = 0; c < NUM_CH; c++) begin
                    next_st.cur_set[c] = cfg_field(bus.cfg_tdata, c);
                end
                if (st.stage_cnt != '0) begin
                    next_st.coef[commit_set] = st.stage[0];
                    for (int k = 0; k < RELOAD_SLOTS - 1; k++) begin
                        next_st.stage[k] = st.stage[k+1];
                    end
                    next_st.stage_cnt = SLOT_W'(st.stage_cnt - 1'b1);
                end
            end
            if (rld_fire) begin
                next_st.stage[st.stage_cnt][st.tap] = bus.rld_tdata;
                if (bus.rld_tlast) begin
                    next_st.tap = '0;
                    next_st.stage_cnt = SLOT_W'(st.stage_cnt + 1'b1);
                end else if (st.tap != TAP_W'(NUM_TAPS - 1)) begin
                    next_st.tap = TAP_W'(st.tap + 1'b1);
                end
            end
            if (adv) begin
                for (int i = LATENCY - 1; i > 0; i--) begin
                    next_st.pv[i] = st.pv[i-1];
                    next_st.pd[i] = st.pd[i-1];
                    next_st.pl[i] = st.pl[i-1];
                    next_st.pu[i] = st.pu[i-1];
                    next_st.ps[i] = st.ps[i-1];
                    next_st.pc[i] = st.pc[i-1];
                end
                next_st.pv[0] = s_fire;
                next_st.pd[0] = bus.s_tdata;
                next_st.pl[0] = in_last;
                next_st.pu[0] = user_now;
                next_st.ps[0] = set_now;
                next_st.pc[0] = st.coef[set_now][0];
            end
        end
        next_st.rst_q = srst_i;
    end

    // The reset stage samples even with the enable low so reset always wins
    always_ff @(posedge mclk_i) begin
        if (ce_i || st.rst_q) begin
            st <= next_st;
        end else if (srst_i) begin
            st.rst_q <= 1'b1;
        end
    end
endmodule

//--- rtl/fsc_stream_host.sv
/*
 Controller on the far side of the filter shell: sources data, config and reload, sinks output.
 Assumes software drives it over AXI4-Lite, one write and one read under way at a time.
*/
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
module fsc_stream_host #(
    parameter int DATA_W = 16,
    parameter int USER_W = 8,
    parameter int CFG_W = 8,
    parameter int COEF_W = 16,
    parameter int SET_W = 1
) (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic [fsc_pkg::FSC_AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [fsc_pkg::FSC_AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    fsc_if.host bus
);
    import fsc_pkg::*;

    typedef struct packed {
        logic s_pend;
        logic [DATA_W-1:0] s_data;
        logic [31:0] flags;
        logic c_pend;
        logic [CFG_W-1:0] c_data;
        logic r_pend;
        logic [COEF_W-1:0] r_data;
        logic r_last;
        logic o_full;
        logic [DATA_W-1:0] o_data;
        logic o_last;
        logic [USER_W-1:0] o_user;
        logic [SET_W-1:0] o_set;
        logic [COEF_W-1:0] o_coef;
        logic [31:0] ctrl;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } fsc_host_state_t;

    fsc_host_state_t st;
    fsc_host_state_t next_st;

    logic busy;
    logic wr_take;
    logic rd_take;
    logic [31:0] wmask;

    // A push register whose channel is still pending stalls the write, which is the back-pressure
    always_comb begin
        case (s_axi_awaddr)
            FSC_REG_SAMPLE: busy = st.s_pend;
            FSC_REG_CONFIG: busy = st.c_pend;
            FSC_REG_RELOAD, FSC_REG_RELOAD_LAST: busy = st.r_pend;
            default: busy = 1'b0;
        endcase
        for (int b = 0; b < 4; b++) begin
            wmask[8*b +: 8] = {8{s_axi_wstrb[b]}};
        end
    end

    // Readies fall with the enable so a request is never lost while state is frozen
    assign wr_take = s_axi_awvalid && s_axi_wvalid && !st.bvalid && !busy && !srst_i && ce_i;
    assign rd_take = s_axi_arvalid && !st.rvalid && !srst_i && ce_i;
    assign s_axi_awready = wr_take;
    assign s_axi_wready = wr_take;
    assign s_axi_arready = rd_take;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;

    // Payloads come straight from held registers; all but tlast and tuser, which follow FLAGS writes, stay stable until taken
    assign bus.s_tvalid = st.s_pend;
    assign bus.s_tdata = st.s_data;
    assign bus.s_tlast = st.flags[FSC_FLAGS_LAST_BIT];
    assign bus.s_tuser = st.flags[FSC_FLAGS_USER_LSB +: USER_W];
    assign bus.cfg_tvalid = st.c_pend;
    assign bus.cfg_tdata = st.c_data;
    assign bus.rld_tvalid = st.r_pend;
    assign bus.rld_tdata = st.r_data;
    assign bus.rld_tlast = st.r_last;
    assign bus.m_tready = st.ctrl[FSC_CTRL_SINK_BIT] && !st.o_full && !srst_i;

    always_comb begin
        next_st = st;
        if (bus.s_tvalid && bus.s_tready) begin
            next_st.s_pend = 1'b0;
        end
        if (bus.cfg_tvalid && bus.cfg_tready) begin
            next_st.c_pend = 1'b0;
        end
        if (bus.rld_tvalid && bus.rld_tready) begin
            next_st.r_pend = 1'b0;
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (wr_take) begin
            next_st.bvalid = 1'b1;
            next_st.bresp = FSC_RESP_OKAY;
            case (s_axi_awaddr)
                FSC_REG_SAMPLE: begin
                    next_st.s_pend = 1'b1;
                    next_st.s_data = s_axi_wdata[DATA_W-1:0];
                end
                FSC_REG_FLAGS: next_st.flags = (st.flags & ~wmask) | (s_axi_wdata & wmask);
                FSC_REG_CONFIG: begin
                    next_st.c_pend = 1'b1;
                    next_st.c_data = s_axi_wdata[CFG_W-1:0];
                end
                FSC_REG_RELOAD, FSC_REG_RELOAD_LAST: begin
                    next_st.r_pend = 1'b1;
                    next_st.r_data = s_axi_wdata[COEF_W-1:0];
                    next_st.r_last = (s_axi_awaddr == FSC_REG_RELOAD_LAST);
                end
                FSC_REG_CTRL: next_st.ctrl = (st.ctrl & ~wmask) | (s_axi_wdata & wmask);
                FSC_REG_STATUS, FSC_REG_OUT_DATA, FSC_REG_OUT_INFO, FSC_REG_OUT_COEF: begin
                    next_st.bresp = FSC_RESP_OKAY;
                end
                default: next_st.bresp = FSC_RESP_SLVERR;
            endcase
        end
        if (rd_take) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = FSC_RESP_OKAY;
            next_st.rdata = '0;
            case (s_axi_araddr)
                FSC_REG_SAMPLE, FSC_REG_CONFIG, FSC_REG_RELOAD, FSC_REG_RELOAD_LAST: begin
                    next_st.rdata = '0;
                end
                FSC_REG_FLAGS: next_st.rdata = st.flags;
                FSC_REG_STATUS: begin
                    next_st.rdata[FSC_ST_SAMPLE_BIT] = st.s_pend;
                    next_st.rdata[FSC_ST_CONFIG_BIT] = st.c_pend;
                    next_st.rdata[FSC_ST_RELOAD_BIT] = st.r_pend;
                    next_st.rdata[FSC_ST_OUT_BIT] = st.o_full;
                end
                FSC_REG_OUT_DATA: begin
                    next_st.rdata = 32'(st.o_data);
                    next_st.o_full = 1'b0;
                end
                FSC_REG_OUT_INFO: begin
                    next_st.rdata[FSC_INFO_USER_LSB +: USER_W] = st.o_user;
                    next_st.rdata[FSC_INFO_LAST_BIT] = st.o_last;
                    next_st.rdata[FSC_INFO_SET_LSB +: SET_W] = st.o_set;
                end
                FSC_REG_OUT_COEF: next_st.rdata = 32'(st.o_coef);
                FSC_REG_CTRL: next_st.rdata = st.ctrl;
                default: next_st.rresp = FSC_RESP_SLVERR;
            endcase
        end
        // Capture cannot meet the clearing read: ready is low while full
        if (bus.m_tvalid && bus.m_tready) begin
            next_st.o_full = 1'b1;
            next_st.o_data = bus.m_tdata;
            next_st.o_last = bus.m_tlast;
            next_st.o_user = bus.m_tuser;
            next_st.o_set = bus.m_set;
            next_st.o_coef = bus.m_coef0;
        end
        if (srst_i) begin
            next_st = '0;
            next_st.flags = FSC_FLAGS_RESET;
            next_st.ctrl = FSC_CTRL_RESET;
        end
    end

    // Reset lasts as long as software holds it, covering the filter's one-cycle need
    always_ff @(posedge mclk_i) begin
        if (ce_i || srst_i) begin
            st <= next_st;
        end
    end
endmodule

//--- bench/fsc_filter_ctrl_checker.sv
/*
 Checker of the stream channels between the filter shell and its controller.
 Assumes one clock, the default interface widths, four channels and a latency of 4.
*/
module fsc_filter_ctrl_checker #(
    parameter int DATA_W = 16,
    parameter int USER_W = 8,
    parameter int CFG_W = 8,
    parameter int SET_W = 1
) (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic s_tvalid,
    input wire logic s_tready,
    input wire logic [DATA_W-1:0] s_tdata,
    input wire logic [USER_W-1:0] s_tuser,
    input wire logic m_tvalid,
    input wire logic m_tready,
    input wire logic [DATA_W-1:0] m_tdata,
    input wire logic [USER_W-1:0] m_tuser,
    input wire logic [SET_W-1:0] m_set,
    input wire logic cfg_tvalid,
    input wire logic cfg_tready,
    input wire logic [CFG_W-1:0] cfg_tdata,
    input wire logic rld_tvalid,
    input wire logic rld_tready,
    input wire logic rld_tlast
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CH_W = 2;
    wire logic [SET_W-1:0] cfg_sel = cfg_tdata[SET_W-1:0];
    wire logic [USER_W-CH_W-1:0] in_hi = s_tuser[USER_W-1:CH_W];
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    // Repeat counts stand for a latency of 4; the tools want plain numbers
    sequence s_in_fire;
        s_tvalid && s_tready && ce_i;
    endsequence
    sequence s_drain3;
        (ce_i && m_tready) [*3];
    endsequence
    sequence s_rld_done;
        rld_tvalid && rld_tready && rld_tlast && ce_i;
    endsequence
    property p_latency;
        s_in_fire ##1 s_drain3 |=> m_tvalid && m_tdata == $past(s_tdata, 4)
            && m_tuser[USER_W-1:CH_W] == $past(in_hi, 4);
    endproperty
    a_latency: assert property (p_latency) else $error("output not delayed by latency");
    property p_cfg_set;
        (cfg_tvalid && cfg_tready && ce_i) ##1 s_drain3 |=> m_set == $past(cfg_sel, 4);
    endproperty
    a_cfg_set: assert property (p_cfg_set) else $error("set not applied to sample");
    property p_cfg_first;
        cfg_tvalid && cfg_tready |-> s_tvalid && s_tready;
    endproperty
    a_cfg_first: assert property (p_cfg_first) else $error("config taken alone");
    property p_stall_in;
        m_tvalid && !m_tready |-> !s_tready;
    endproperty
    a_stall_in: assert property (p_stall_in) else $error("input taken under stall");
    property p_hold_out;
        m_tvalid && !m_tready && ce_i |=> m_tvalid && $stable(m_tdata) && $stable(m_tuser);
    endproperty
    a_hold_out: assert property (p_hold_out) else $error("output moved while stalled");
    property p_ce_hold;
        !ce_i && !$past(srst_i) |=> $stable(m_tvalid) && $stable(m_tdata) && $stable(m_set);
    endproperty
    a_ce_hold: assert property (p_ce_hold) else $error("state moved with enable low");
    // Reset must act whatever the enable does, so these two are never disabled
    property p_rst_ready;
        disable iff (1'b0) srst_i |=> !s_tready && !cfg_tready && !rld_tready;
    endproperty
    a_rst_ready: assert property (p_rst_ready) else $error("ready during reset");
    property p_rst_clear;
        disable iff (1'b0) srst_i |-> ##2 !m_tvalid;
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("output not cleared");
    property p_rld_full;
        s_rld_done ##1 (!(cfg_tvalid && cfg_tready)) [*2] |-> !rld_tready;
    endproperty
    a_rld_full: assert property (p_rld_full) else $error("reload taken with slot full");
endmodule

//--- bench/fsc_filter_ctrl_tb.sv
/*
 Testbench: filter shell and controller joined, driven over AXI4-Lite.
 Assumes the register map of the package and one reload slot.
*/
module fsc_filter_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fsc_pkg::*;
    logic mclk_i = 1'b0;
    logic srst_i = 1'b1;
    logic ce_i = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rsp;
    logic [31:0] rdata, rd;
    int n_errors = 0;
    int total_checks = 0;
    logic exp_last = 1'b0;
    fsc_if bus_if ();
    always #10 mclk_i = ~mclk_i;
    fsc_filter_ctrl #(.USER_MODE(fsc_user_and_tag)) fsc_filter_ctrl_i (.mclk_i(mclk_i),
        .srst_i(srst_i), .ce_i(ce_i), .bus(bus_if.dev));
    fsc_stream_host fsc_stream_host_i (.mclk_i(mclk_i), .srst_i(srst_i), .ce_i(ce_i),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .bus(bus_if.host));
    fsc_filter_ctrl_checker fsc_filter_ctrl_checker_i (.mclk_i(mclk_i), .srst_i(srst_i),
        .ce_i(ce_i), .s_tvalid(bus_if.s_tvalid), .s_tready(bus_if.s_tready),
        .s_tdata(bus_if.s_tdata), .s_tuser(bus_if.s_tuser), .m_tvalid(bus_if.m_tvalid),
        .m_tready(bus_if.m_tready), .m_tdata(bus_if.m_tdata), .m_tuser(bus_if.m_tuser),
        .m_set(bus_if.m_set), .cfg_tvalid(bus_if.cfg_tvalid), .cfg_tready(bus_if.cfg_tready),
        .cfg_tdata(bus_if.cfg_tdata), .rld_tvalid(bus_if.rld_tvalid),
        .rld_tready(bus_if.rld_tready), .rld_tlast(bus_if.rld_tlast));
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task close_out;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Pushes wait on awready, which stays low while the channel is still pending
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge mclk_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge mclk_i); while (awready !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge mclk_i); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask
    task rdr(input logic [7:0] a);
        @(posedge mclk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge mclk_i); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge mclk_i); while (rvalid !== 1'b1);
        rready <= 1'b0;
        rd = rdata;
        rsp = rresp;
    endtask
    task push(input logic [15:0] d, input logic lst);
        exp_last = lst;
        wr(FSC_REG_FLAGS, {16'h0, 8'hA5, 7'h0, lst}, FSC_RESP_OKAY);
        wr(FSC_REG_SAMPLE, {16'h0, d}, FSC_RESP_OKAY);
    endtask
    // Low tuser bits carry the channel counter, upper ones pass through
    task pull(input logic [15:0] d, input logic [1:0] ch, input logic st, input logic [15:0] cf);
        int n;
        n = 0;
        do begin
            rdr(FSC_REG_STATUS);
            n++;
        end while (rd[FSC_ST_OUT_BIT] !== 1'b1 && n < 50);
        chk("out_full", 32'h1, {31'h0, rd[FSC_ST_OUT_BIT]});
        rdr(FSC_REG_OUT_INFO);
        chk("out_user", {24'h0, 6'h29, ch}, {24'h0, rd[7:0]});
        chk("out_set", {31'h0, st}, {31'h0, rd[FSC_INFO_SET_LSB]});
        chk("out_last", {31'h0, exp_last}, {31'h0, rd[FSC_INFO_LAST_BIT]});
        rdr(FSC_REG_OUT_COEF);
        chk("out_coef", {16'h0, cf}, {16'h0, rd[15:0]});
        rdr(FSC_REG_OUT_DATA);
        chk("out_data", {16'h0, d}, {16'h0, rd[15:0]});
    endtask
    initial begin
        #1_000_000;
        n_errors++;
        close_out;
    end
    initial begin
        repeat (2) @(posedge mclk_i);
        srst_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        rdr(FSC_REG_CTRL);
        chk("ctrl_reset", FSC_CTRL_RESET, rd);
        rdr(FSC_REG_FLAGS);
        chk("flags_reset", FSC_FLAGS_RESET, rd);
        wr(8'h40, 32'h1, FSC_RESP_SLVERR);
        rdr(8'h40);
        chk("unmapped_rresp", {30'h0, FSC_RESP_SLVERR}, {30'h0, rsp});
        push(16'h1111, 1'b0);
        pull(16'h1111, 2'd0, 1'b0, 16'h0);
        push(16'h2222, 1'b1);
        pull(16'h2222, 2'd1, 1'b0, 16'h0);
        push(16'h3333, 1'b0);
        pull(16'h3333, 2'd0, 1'b0, 16'h0);
        for (int i = 0; i < 4; i++) begin
            wr(FSC_REG_RELOAD, 32'h7 + i, FSC_RESP_OKAY);
        end
        wr(FSC_REG_RELOAD_LAST, 32'hB, FSC_RESP_OKAY);
        wr(FSC_REG_CONFIG, 32'h1, FSC_RESP_OKAY);
        push(16'h4444, 1'b1);
        pull(16'h4444, 2'd1, 1'b0, 16'h0);
        rdr(FSC_REG_STATUS);
        chk("cfg_pending", 32'h1, {31'h0, rd[FSC_ST_CONFIG_BIT]});
        push(16'h5555, 1'b0);
        pull(16'h5555, 2'd0, 1'b1, 16'h0);
        push(16'h6666, 1'b0);
        pull(16'h6666, 2'd1, 1'b1, 16'h7);
        wr(FSC_REG_CTRL, 32'h0, FSC_RESP_OKAY);
        push(16'h7777, 1'b0);
        repeat (10) @(posedge mclk_i);
        push(16'h8888, 1'b0);
        repeat (10) @(posedge mclk_i);
        rdr(FSC_REG_STATUS);
        chk("stall_status", 32'h1, {28'h0, rd[3:0]});
        wr(FSC_REG_CTRL, 32'h1, FSC_RESP_OKAY);
        pull(16'h7777, 2'd2, 1'b1, 16'h7);
        pull(16'h8888, 2'd3, 1'b1, 16'h7);
        push(16'h9999, 1'b0);
        ce_i <= 1'b0;
        repeat (6) @(posedge mclk_i);
        ce_i <= 1'b1;
        pull(16'h9999, 2'd0, 1'b1, 16'h7);
        srst_i <= 1'b1;
        @(posedge mclk_i);
        srst_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        rdr(FSC_REG_FLAGS);
        chk("flags_after_pulse", FSC_FLAGS_RESET, rd);
        push(16'hAAAA, 1'b0);
        pull(16'hAAAA, 2'd0, 1'b0, 16'h0);
        close_out;
    end
endmodule
